// ===== rtl/axis_if_pkg.sv
// Purpose: shared constants and carriers for the servo driver axis interface
// Assumes: four axes, 40 MHz clock, 32-bit position counters
// Notes: compare on axes 1-2, latch on axes 3-4
package axis_if_pkg;
   localparam int unsigned num_axes = 4;
   localparam int unsigned num_cmp = 2;
   localparam int unsigned num_ltc = 2;
   localparam int unsigned ltc_base = 2;
   localparam int unsigned cnt_width = 32;
   localparam real clk_mhz = 40.0;
   // compare pulse width, nanoseconds
   localparam real cmp_pulse_ns = 1000.0;
   localparam int unsigned cmp_pulse_cycles = (int'(cmp_pulse_ns * clk_mhz / 1000.0) < 1) ? 1 :
      int'(cmp_pulse_ns * clk_mhz / 1000.0);
   localparam logic [15:0] cmp_pulse_count = cmp_pulse_cycles[15:0];
   localparam logic [cnt_width-1:0] cnt_reset = 32'h0000_0000;
   localparam logic [cnt_width-1:0] cnt_one = 32'h0000_0001;

   // per-axis driver-side inputs
   typedef struct packed {
      logic in_position;
      logic alarm_in;
      logic driver_ready_in;
      logic enc_phase_a;
      logic enc_phase_b;
      logic pulser_phase_a;
      logic pulser_phase_b;
   } axis_pins_type;

   // per-axis software control
   typedef struct packed {
      logic servo_on;
      logic home_done;
      logic limit_active;
      logic emergency_stop;
      logic step_req;
      logic dir_req;
   } axis_ctrl_type;

   // per-axis status toward software
   typedef struct packed {
      logic in_position;
      logic alarm;
      logic driver_ready;
      logic halted;
   } axis_stat_type;

   typedef enum logic [2:0] {
      cmp_idle = 3'b001,
      cmp_pulse = 3'b010,
      cmp_hold = 3'b100
   } cmp_state_type;

   // two-bit quadrature step decode: +1, -1 or nothing
   function automatic logic [1:0] quad_step(input logic [1:0] prev, input logic [1:0] cur);
      logic [1:0] r;
      r = 2'h0;
      unique case ({prev, cur})
         4'b0001, 4'b0111, 4'b1110, 4'b1000: r = 2'h1;
         4'b0010, 4'b1011, 4'b1101, 4'b0100: r = 2'h2;
         default: r = 2'h0;
      endcase
      return r;
   endfunction : quad_step
endpackage : axis_if_pkg

// ===== rtl/quad_counter.sv
// Purpose: synchronised quadrature decoder with up/down position counter
// Assumes: phase inputs from pins, asynchronous to clk
// Notes: double transitions are dropped, not guessed
`timescale 1ns/10ps
`default_nettype none
module quad_counter (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // phase pins
   input wire logic phase_a,
   input wire logic phase_b,
   // count
   output logic [axis_if_pkg::cnt_width-1:0] count,
   output logic step
);
   import axis_if_pkg::*;
   logic [1:0] meta_reg, sync_reg, prev_reg;
   logic [cnt_width-1:0] count_reg, count_next;
   logic step_reg, step_next;
   logic [2:0] fill_reg, fill_next;
   logic [1:0] dir;

   always_comb begin
      // no decode until prev holds a real pin level; a resting phase pair is not a step
      fill_next = {fill_reg[1:0], 1'b1};
      dir = fill_reg[2] ? quad_step(prev_reg, sync_reg) : 2'h0;
      count_next = count_reg;
      step_next = 1'b0;
      if (dir == 2'h1) begin
         count_next = count_reg + cnt_one;
         step_next = 1'b1;
      end else if (dir == 2'h2) begin
         count_next = count_reg - cnt_one;
         step_next = 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_reg <= 2'h0;
         sync_reg <= 2'h0;
         prev_reg <= 2'h0;
         count_reg <= cnt_reset;
         step_reg <= 1'b0;
         fill_reg <= 3'h0;
      end else begin
         meta_reg <= {phase_a, phase_b};
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
         count_reg <= count_next;
         step_reg <= step_next;
         fill_reg <= fill_next;
      end
   end

   assign count = count_reg;
   assign step = step_reg;
endmodule : quad_counter
`default_nettype wire

// ===== rtl/servo_driver_axis_interface.sv
// Purpose: per-axis driver interface: alarm, in-position, clear, servo-on, compare, latch, pulser
// Assumes: one 40 MHz clock; all pin inputs asynchronous
// Notes: control and status are plain ports, no register bus
`timescale 1ns/10ps
`default_nettype none
// What this block does
// RULE1: assert deviation clear on four stop events
// RULE2: deviation clear resets external driver error
// RULE3: in-position input means zero following error
// RULE4: active alarm halts axis command outputs
// RULE5: software servo-on output per axis
// RULE6: sample driver-ready input per axis
// RULE7: compare pulses on axes one, two
// RULE8: compare polarity selectable, idles high after reset
// RULE9: latch trigger captures counter, axes three, four
// RULE10: pulser phases decoded into motion commands
// RULE11: position counter driven by encoder phases
// RULE12: quadrature pulser decode, drop double transitions
module servo_driver_axis_interface (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // driver pins
   input wire axis_if_pkg::axis_pins_type [3:0] pins,
   input wire logic [1:0] latch_trigger_in,
   output logic [3:0] deviation_clear_out,
   output logic [3:0] servo_on_out,
   output logic [3:0] step_pulse,
   output logic [3:0] motion_sense,
   output logic [1:0] compare_pulse_out,
   // software side
   input wire axis_if_pkg::axis_ctrl_type [3:0] ctrl,
   input wire logic [1:0] cmp_idle_low,
   input wire logic [1:0][axis_if_pkg::cnt_width-1:0] cmp_value,
   input wire logic [1:0] cmp_enable,
   output axis_if_pkg::axis_stat_type [3:0] status,
   output logic [3:0][axis_if_pkg::cnt_width-1:0] enc_count,
   output logic [3:0][axis_if_pkg::cnt_width-1:0] pulser_count,
   output logic [1:0][axis_if_pkg::cnt_width-1:0] latch_value,
   output logic [1:0] latch_valid
);
   import axis_if_pkg::*;

   logic [num_axes-1:0][cnt_width-1:0] enc_cnt, pls_cnt;
   logic [num_axes-1:0] pls_step;
   logic [num_axes-1:0] alm_meta_reg, alm_sync_reg;
   logic [num_axes-1:0] inp_meta_reg, inp_sync_reg;
   logic [num_axes-1:0] rdy_meta_reg, rdy_sync_reg;
   logic [num_ltc-1:0] ltc_meta_reg, ltc_sync_reg, ltc_prev_reg;

   // per-axis encoder and pulser decoders
   genvar g;
   generate
      for (g = 0; g < num_axes; g++) begin : axis_g
         quad_counter enc_u ( // RULE11
            .clk(clk),
            .rst(rst),
            .phase_a(pins[g].enc_phase_a),
            .phase_b(pins[g].enc_phase_b),
            .count(enc_cnt[g]),
            .step()
         );
         quad_counter pls_u ( // RULE10 RULE12
            .clk(clk),
            .rst(rst),
            .phase_a(pins[g].pulser_phase_a),
            .phase_b(pins[g].pulser_phase_b),
            .count(pls_cnt[g]),
            .step(pls_step[g])
         );
      end
   endgenerate

   // input synchronisers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         alm_meta_reg <= 4'h0;
         alm_sync_reg <= 4'h0;
         inp_meta_reg <= 4'h0;
         inp_sync_reg <= 4'h0;
         rdy_meta_reg <= 4'h0;
         rdy_sync_reg <= 4'h0;
         ltc_meta_reg <= 2'h0;
         ltc_sync_reg <= 2'h0;
      end else begin
         for (int i = 0; i < num_axes; i++) begin
            alm_meta_reg[i] <= pins[i].alarm_in;
            inp_meta_reg[i] <= pins[i].in_position;
            rdy_meta_reg[i] <= pins[i].driver_ready_in;
         end
         alm_sync_reg <= alm_meta_reg;
         inp_sync_reg <= inp_meta_reg;
         rdy_sync_reg <= rdy_meta_reg;
         ltc_meta_reg <= latch_trigger_in;
         ltc_sync_reg <= ltc_meta_reg;
      end
   end

   // axis control group
   logic [3:0] clear_reg, clear_next;
   logic [3:0] servo_on_out_reg, servo_on_out_next;
   logic [3:0] step_reg, step_next;
   logic [3:0] sense_reg, sense_next;
   logic [3:0] halted_reg, halted_next;
   logic [3:0] alm_prev_reg, alm_prev_next;
   axis_stat_type [3:0] stat_reg, stat_next;
   logic [3:0][cnt_width-1:0] enc_reg, enc_next, pls_reg, pls_next;

   always_comb begin
      for (int i = 0; i < num_axes; i++) begin
         alm_prev_next[i] = alm_sync_reg[i];
         // alarm halts outputs until an emergency stop or home acknowledges it
         halted_next[i] = alm_sync_reg[i] | (halted_reg[i] & ~ctrl[i].emergency_stop & ~ctrl[i].home_done);
         // held while a stop input is high, one cycle on alarm onset; driver drops its following error on it
         clear_next[i] = ctrl[i].home_done | ctrl[i].limit_active // RULE1 RULE2
            | (alm_sync_reg[i] & ~alm_prev_reg[i]) | ctrl[i].emergency_stop;
         servo_on_out_next[i] = ctrl[i].servo_on; // RULE5
         // command from software or from the manual pulser
         if (alm_sync_reg[i] | halted_reg[i]) begin // RULE4
            step_next[i] = 1'b0;
            sense_next[i] = 1'b0;
         end else if (pls_step[i]) begin // RULE10
            step_next[i] = 1'b1;
            sense_next[i] = pls_cnt[i] != pls_reg[i] && (pls_cnt[i] - pls_reg[i]) == cnt_one;
         end else begin
            step_next[i] = ctrl[i].step_req;
            sense_next[i] = ctrl[i].dir_req;
         end
         stat_next[i].in_position = inp_sync_reg[i]; // RULE3
         stat_next[i].alarm = alm_sync_reg[i];
         stat_next[i].driver_ready = rdy_sync_reg[i]; // RULE6
         stat_next[i].halted = halted_next[i];
         enc_next[i] = enc_cnt[i];
         pls_next[i] = pls_cnt[i];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         clear_reg <= 4'h0;
         servo_on_out_reg <= 4'h0;
         step_reg <= 4'h0;
         sense_reg <= 4'h0;
         halted_reg <= 4'h0;
         alm_prev_reg <= 4'h0;
         stat_reg <= '0;
         enc_reg <= '0;
         pls_reg <= '0;
      end else begin
         clear_reg <= clear_next;
         servo_on_out_reg <= servo_on_out_next;
         step_reg <= step_next;
         sense_reg <= sense_next;
         halted_reg <= halted_next;
         alm_prev_reg <= alm_prev_next;
         stat_reg <= stat_next;
         enc_reg <= enc_next;
         pls_reg <= pls_next;
      end
   end

   // compare group, axes 1 and 2
   cmp_state_type [1:0] cmp_state_reg, cmp_state_next;
   logic [1:0][15:0] cmp_cnt_reg, cmp_cnt_next;
   logic [1:0] cmp_out_reg, cmp_out_next;

   always_comb begin
      for (int i = 0; i < num_cmp; i++) begin
         cmp_state_next[i] = cmp_state_reg[i];
         cmp_cnt_next[i] = cmp_cnt_reg[i];
         unique case (cmp_state_reg[i])
            cmp_idle: begin
               if (cmp_enable[i] && enc_cnt[i] == cmp_value[i]) begin // RULE7
                  cmp_state_next[i] = cmp_pulse;
                  cmp_cnt_next[i] = cmp_pulse_count;
               end
            end
            cmp_pulse: begin
               cmp_cnt_next[i] = cmp_cnt_reg[i] - 16'h0001;
               if (cmp_cnt_reg[i] == 16'h0001) begin
                  cmp_state_next[i] = cmp_hold;
               end
            end
            cmp_hold: begin
               // rearm only once the counter leaves the match value
               if (enc_cnt[i] != cmp_value[i]) begin
                  cmp_state_next[i] = cmp_idle;
               end
            end
            default: cmp_state_next[i] = cmp_idle;
         endcase
         // idle level follows polarity; reset value of select gives idle high
         cmp_out_next[i] = (cmp_state_next[i] == cmp_pulse) ^ ~cmp_idle_low[i]; // RULE8
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cmp_state_reg <= '{cmp_idle, cmp_idle};
         cmp_cnt_reg <= '0;
         cmp_out_reg <= 2'h3; // RULE8
      end else begin
         cmp_state_reg <= cmp_state_next;
         cmp_cnt_reg <= cmp_cnt_next;
         cmp_out_reg <= cmp_out_next;
      end
   end

   // latch group, axes 3 and 4
   logic [1:0][cnt_width-1:0] ltc_val_reg, ltc_val_next;
   logic [1:0] ltc_vld_reg, ltc_vld_next;

   always_comb begin
      for (int i = 0; i < num_ltc; i++) begin
         ltc_val_next[i] = ltc_val_reg[i];
         ltc_vld_next[i] = 1'b0;
         if (ltc_sync_reg[i] & ~ltc_prev_reg[i]) begin // RULE9
            ltc_val_next[i] = enc_cnt[i + ltc_base];
            ltc_vld_next[i] = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ltc_val_reg <= '0;
         ltc_vld_reg <= 2'h0;
         ltc_prev_reg <= 2'h0;
      end else begin
         ltc_val_reg <= ltc_val_next;
         ltc_vld_reg <= ltc_vld_next;
         ltc_prev_reg <= ltc_sync_reg;
      end
   end

   assign deviation_clear_out = clear_reg;
   assign servo_on_out = servo_on_out_reg;
   assign step_pulse = step_reg;
   assign motion_sense = sense_reg;
   assign compare_pulse_out = cmp_out_reg;
   assign status = stat_reg;
   assign enc_count = enc_reg;
   assign pulser_count = pls_reg;
   assign latch_value = ltc_val_reg;
   assign latch_valid = ltc_vld_reg;
endmodule : servo_driver_axis_interface
`default_nettype wire

// ===== testbench/servo_axis_properties.sv
// Purpose: timing checks on the axis interface ports
// Assumes: one clock domain, async active-high reset
// Notes: compare checks watch channel 0 only
`timescale 1ns/10ps
`default_nettype none
module servo_axis_checker (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // driver side
   input wire axis_if_pkg::axis_pins_type [3:0] pins,
   input wire logic [3:0] deviation_clear_out,
   input wire logic [3:0] servo_on_out,
   input wire logic [3:0] step_pulse,
   input wire logic [1:0] compare_pulse_out,
   // software side
   input wire axis_if_pkg::axis_ctrl_type [3:0] ctrl,
   input wire logic [1:0] cmp_idle_low,
   input wire logic [1:0][axis_if_pkg::cnt_width-1:0] cmp_value,
   input wire logic [1:0] cmp_enable,
   input wire axis_if_pkg::axis_stat_type [3:0] status,
   input wire logic [3:0][axis_if_pkg::cnt_width-1:0] enc_count,
   input wire logic [1:0][axis_if_pkg::cnt_width-1:0] latch_value,
   input wire logic [1:0] latch_valid
);
   import axis_if_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic act;
   logic [7:0] run_reg, run_next;
   // active means output sits at the level opposite its idle
   assign act = compare_pulse_out[0] == cmp_idle_low[0];
   assign run_next = act ? run_reg + 8'h01 : 8'h00;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         run_reg <= 8'h00;
      end else begin
         run_reg <= run_next;
      end
   end
   for (genvar i = 0; i < 4; i++) begin : g_axis
      sequence s_alarm_held;
         pins[i].alarm_in [*4];
      endsequence
      property p_clear;
         ctrl[i].emergency_stop || ctrl[i].limit_active || ctrl[i].home_done |=> deviation_clear_out[i];
      endproperty
      property p_alarm_gate;
         s_alarm_held |-> !step_pulse[i];
      endproperty
      property p_servo_on;
         $changed(ctrl[i].servo_on) |=> servo_on_out[i] == $past(ctrl[i].servo_on);
      endproperty
      property p_in_pos;
         (pins[i].in_position && !rst) [*4] |-> status[i].in_position;
      endproperty
      property p_enc_unit;
         $changed(enc_count[i]) |-> enc_count[i] == $past(enc_count[i]) + cnt_one
            || $past(enc_count[i]) == enc_count[i] + cnt_one;
      endproperty
      a_clear: assert property (p_clear) else $error("clear missing after stop event");
      a_alarm_gate: assert property (p_alarm_gate) else $error("step during alarm");
      a_servo_on: assert property (p_servo_on) else $error("servo on not following");
      a_in_pos: assert property (p_in_pos) else $error("in position not reported");
      a_enc_unit: assert property (p_enc_unit) else $error("count jumped");
   end
   sequence s_match;
      cmp_enable[0] && enc_count[0] == cmp_value[0] && $changed(enc_count[0]);
   endsequence
   property p_cmp_start;
      s_match |-> ##[0:1] act;
   endproperty
   property p_cmp_cause;
      $rose(act) && $stable(cmp_idle_low) |-> enc_count[0] == cmp_value[0] && $past(cmp_enable[0]);
   endproperty
   property p_cmp_len;
      $fell(act) && $past(cmp_idle_low, 2) == cmp_idle_low |-> run_reg == cmp_pulse_count[7:0];
   endproperty
   property p_latch_val;
      latch_valid[0] && $stable(enc_count[2]) |-> ##[0:1] latch_value[0] == enc_count[2];
   endproperty
   a_cmp_start: assert property (p_cmp_start) else $error("no compare pulse");
   a_cmp_cause: assert property (p_cmp_cause) else $error("stray compare pulse");
   a_cmp_len: assert property (p_cmp_len) else $error("compare pulse width");
   a_latch_val: assert property (p_latch_val) else $error("latched value wrong");
endmodule : servo_axis_checker
`default_nettype wire

// ===== testbench/servo_drive_model.sv
// Purpose: behavioural servo driver for one axis
// Assumes: each step pulse adds one to following error
// Notes: encoder moves one state per enc_step request
`timescale 1ns/10ps
`default_nettype none
module servo_drive_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // from the axis
   input wire logic step,
   input wire logic clear,
   input wire logic servo_on,
   // bench hooks
   input wire logic alarm_cmd,
   input wire logic enc_step,
   input wire logic enc_up,
   // to the axis
   output logic in_position,
   output logic alarm_in,
   output logic driver_ready_in,
   output logic enc_a,
   output logic enc_b
);
   logic [7:0] err_reg;
   logic [1:0] ph_reg;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         err_reg <= 8'h00;
         ph_reg <= 2'h0;
      end else begin
         err_reg <= clear ? 8'h00 : err_reg + {7'h00, step};
         ph_reg <= enc_step ? (enc_up ? ph_reg + 2'h1 : ph_reg - 2'h1) : ph_reg;
      end
   end
   assign in_position = err_reg == 8'h00;
   assign alarm_in = alarm_cmd;
   assign driver_ready_in = servo_on;
   // gray order 00 01 11 10 counts up
   assign enc_a = ph_reg[1];
   assign enc_b = ph_reg[1] ^ ph_reg[0];
endmodule : servo_drive_model
`default_nettype wire

// ===== testbench/servo_driver_axis_interface_bench.sv
// Purpose: self-checking bench for the axis interface
// Assumes: one driver model per axis
// Notes: outputs are sampled on the falling edge
`timescale 1ns/10ps
`default_nettype none
module servo_driver_axis_interface_bench;
   import axis_if_pkg::*;
   logic clk, rst, enc_up;
   wire axis_pins_type [3:0] pins;
   axis_ctrl_type [3:0] ctrl;
   axis_stat_type [3:0] status;
   logic [1:0] latch_trigger_in, cmp_idle_low, cmp_enable, compare_pulse_out, latch_valid;
   logic [3:0] deviation_clear_out, servo_on_out, step_pulse, motion_sense, alarm_cmd, enc_step, pa, pb;
   logic [1:0][cnt_width-1:0] cmp_value, latch_value;
   logic [3:0][cnt_width-1:0] enc_count, pulser_count;
   int n_fail, checks_done, cycles;
   servo_driver_axis_interface dut (.clk, .rst, .pins, .latch_trigger_in, .deviation_clear_out, .servo_on_out,
      .step_pulse, .motion_sense, .compare_pulse_out, .ctrl, .cmp_idle_low, .cmp_value, .cmp_enable, .status,
      .enc_count, .pulser_count, .latch_value, .latch_valid);
   for (genvar i = 0; i < 4; i++) begin : g_drv
      servo_drive_model drv (.clk, .rst, .step(step_pulse[i]), .clear(deviation_clear_out[i]),
         .servo_on(servo_on_out[i]), .alarm_cmd(alarm_cmd[i]), .enc_step(enc_step[i]), .enc_up,
         .in_position(pins[i].in_position), .alarm_in(pins[i].alarm_in),
         .driver_ready_in(pins[i].driver_ready_in), .enc_a(pins[i].enc_phase_a), .enc_b(pins[i].enc_phase_b));
      assign pins[i].pulser_phase_a = pa[i];
      assign pins[i].pulser_phase_b = pb[i];
   end
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task test_done;
      $display("comparisons %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : test_done
   // ceiling well above the few hundred cycles the tests need
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_fail++;
         test_done();
      end
   end
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check
   task w(input int n);
      repeat (n) @(posedge clk);
   endtask : w
   task ws(input int n);
      w(n);
      @(negedge clk);
   endtask : ws
   // quadrature edges kept four cycles apart
   task move(input int a, input int n, input logic up);
      repeat (n) begin
         enc_up <= up;
         enc_step[a] <= 1'b1;
         w(1);
         enc_step[a] <= 1'b0;
         w(3);
      end
      w(4);
   endtask : move
   task t_clear;
      ctrl[1].step_req <= 1'b1;
      w(1);
      ctrl[1].step_req <= 1'b0;
      ws(6);
      check(32'(status[1].in_position), 32'h0);
      for (int k = 0; k < 3; k++) begin
         w(1);
         ctrl[k+1].emergency_stop <= k == 0;
         ctrl[k+1].limit_active <= k == 1;
         ctrl[k+1].home_done <= k == 2;
         ws(2);
         check(32'(deviation_clear_out), 32'h1 << (k + 1));
         w(1);
         ctrl <= '0;
         ws(2);
         check(32'(deviation_clear_out), 32'h0);
      end
      check(32'(status[1].in_position), 32'h1);
      w(1);
      ctrl[0].servo_on <= 1'b1;
      ctrl[3].servo_on <= 1'b1;
      ws(6);
      check(32'(servo_on_out), 32'h9);
      check(32'({status[3].driver_ready, status[1].driver_ready}), 32'h2);
      $display("clear test done");
   endtask : t_clear
   task t_alarm;
      logic seen;
      seen = 1'b0;
      w(1);
      alarm_cmd[0] <= 1'b1;
      ctrl[0].step_req <= 1'b1;
      ctrl[0].dir_req <= 1'b1;
      repeat (8) begin
         @(negedge clk);
         seen = seen | deviation_clear_out[0];
      end
      check(32'(seen), 32'h1);
      check(32'({step_pulse[0], motion_sense[0], status[0].halted, status[0].alarm}), 32'h3);
      // halt only lifts once the synchronised alarm is low
      w(1);
      alarm_cmd[0] <= 1'b0;
      w(3);
      ctrl[0].emergency_stop <= 1'b1;
      w(1);
      ctrl[0].emergency_stop <= 1'b0;
      ws(8);
      check(32'({step_pulse[0], motion_sense[0], status[0].halted}), 32'h6);
      w(1);
      ctrl[0].step_req <= 1'b0;
      ctrl[0].dir_req <= 1'b0;
      $display("alarm test done");
   endtask : t_alarm
   task t_compare;
      for (int c = 0; c < 2; c++) begin
         w(1);
         cmp_value[c] <= 32'h0000_0003;
         cmp_enable[c] <= 1'b1;
         move(c, 3, 1'b1);
         ws(3);
         check(enc_count[c], 32'h0000_0003);
         check(32'(compare_pulse_out[c]), 32'h0);
         ws(45);
         check(32'(compare_pulse_out[c]), 32'h1);
         w(1);
         cmp_idle_low[c] <= 1'b1;
         ws(3);
         check(32'(compare_pulse_out[c]), 32'h0);
         w(1);
         move(c, 1, 1'b0);
         move(c, 1, 1'b1);
         ws(3);
         check(32'(compare_pulse_out[c]), 32'h1);
      end
      $display("compare test done");
   endtask : t_compare
   task t_latch;
      w(1);
      move(2, 5, 1'b1);
      latch_trigger_in[0] <= 1'b1;
      move(3, 2, 1'b0);
      latch_trigger_in[1] <= 1'b1;
      ws(6);
      check(latch_value[0], 32'h0000_0005);
      check(latch_value[1], 32'hffff_fffe);
      w(1);
      latch_trigger_in <= 2'h0;
      $display("latch test done");
   endtask : t_latch
   task t_pulser;
      // last move is a double transition and must not count
      logic [1:0] ph [6];
      ph = '{2'h1, 2'h3, 2'h2, 2'h0, 2'h2, 2'h1};
      foreach (ph[j]) begin
         w(1);
         {pa[1], pb[1]} <= ph[j];
         w(3);
      end
      ws(6);
      check(pulser_count[1], 32'h0000_0003);
      $display("pulser test done");
   endtask : t_pulser
   initial begin
      rst = 1'b1;
      ctrl = '0;
      {latch_trigger_in, cmp_idle_low, cmp_enable, alarm_cmd, enc_step, pa, pb, enc_up} = '0;
      cmp_value = '0;
      {n_fail, checks_done, cycles} = '0;
      ws(4);
      check(32'(compare_pulse_out), 32'h3);
      w(1);
      rst <= 1'b0;
      t_clear();
      t_alarm();
      t_compare();
      t_latch();
      t_pulser();
      test_done();
   end
endmodule : servo_driver_axis_interface_bench
bind servo_driver_axis_interface servo_axis_checker chk (.clk, .rst, .pins, .deviation_clear_out, .servo_on_out,
   .step_pulse, .compare_pulse_out, .ctrl, .cmp_idle_low, .cmp_value, .cmp_enable, .status, .enc_count,
   .latch_value, .latch_valid);
`default_nettype wire
